// *** design/mite_core.v ***
// Function
// [RULE1] Instruction cycle is four system clocks
// [RULE2] Branch, call, table read take two cycles
// [RULE3] Jump, call, return, interrupt return add cycle
// [RULE4] Writing pc_low_byte jumps, costs extra cycle
// [RULE5] Taken skip costs extra cycle, else one
// [RULE6] Conditional tests byte or bit, may skip
// [RULE7] Add carries above 255, subtract borrows below 0
// [RULE8] Increment or decrement by exactly one
// [RULE9] Logic ops set zero on zero result
// [RULE10] Rotates shift one bit, carry variants through carry
// [RULE11] Bit set/clear changes only chosen bit
// [RULE12] Return resumes after call; jump saves nothing
// [RULE13] Data moves through accumulator, three move forms
// [RULE14] Halt instruction enters power-down
// [RULE15] Other instructions just advance program counter
`timescale 1ns/1ps
`default_nettype none
`include "mite_core_map.vh"

module mite_core
#(
   parameter STACK_DEPTH = 4,
   parameter SP_W = 2
)
(
   // Clock and reset
   input wire core_clk_in,
   input wire rst_in,
   // Program memory, one-clock read latency
   output reg [7:0] prog_addr_out,
   input wire [15:0] prog_data_in,
   // Data memory, combinational read, no latency
   output reg [7:0] dm_addr_out,
   input wire [7:0] dm_rdata_in,
   output reg [7:0] dm_wdata_out,
   output reg dm_we_out,
   // Wake pin for leaving power-down
   input wire wake_in,
   // Core status
   output reg [7:0] acc_out,
   output reg carry_out,
   output reg zero_out,
   output reg halted_out,
   output reg retire_out
);

   // One-hot phases of an instruction cycle
   localparam PH_FETCH = 4'b0001;
   localparam PH_DECODE = 4'b0010;
   localparam PH_READ = 4'b0100;
   localparam PH_EXEC = 4'b1000;

   reg [3:0] phase_reg; // Current phase
   reg [7:0] pc_reg; // Program counter (pc_low_byte)
   reg [15:0] instr_reg; // Latched instruction
   reg [7:0] oper_reg; // Latched data operand
   reg extra_reg; // Next cycle is the added one
   reg tabrd_reg; // Added cycle serves a table read
   reg [7:0] stack_mem [0:STACK_DEPTH-1]; // Return addresses
   reg [SP_W-1:0] sp_reg; // Stack pointer
   reg wake_meta_reg; // Wake synchroniser, first stage
   reg wake_sync_reg; // Wake synchroniser, second stage

   // Instruction fields
   wire [4:0] op;
   wire [2:0] bsel;
   wire [7:0] arg;
   assign op = instr_reg[`MITE_OP_MSB:`MITE_OP_LSB];
   assign bsel = instr_reg[`MITE_BIT_MSB:`MITE_BIT_LSB];
   assign arg = instr_reg[`MITE_ARG_MSB:`MITE_ARG_LSB];

   // ALU results
   wire [7:0] alu_res;
   wire alu_c;
   wire alu_c_upd;
   wire alu_z_upd;

   mite_alu u_alu
   (
      .op_in(op),
      .bit_in(bsel),
      .acc_in(acc_out),
      .mem_in(oper_reg),
      .imm_in(arg),
      .carry_in(carry_out),
      .res_out(alu_res),
      .carry_new_out(alu_c),
      .carry_upd_out(alu_c_upd),
      .zero_upd_out(alu_z_upd)
   );

   // Result goes to accumulator, or back to memory
   reg to_acc;
   reg to_mem;
   always @*
   begin
      to_acc = 1'b0;
      to_mem = 1'b0;
      case (op)
         `MITE_OP_MOV_A_M, `MITE_OP_MOV_A_X, `MITE_OP_ADD_M,
         `MITE_OP_ADD_X, `MITE_OP_SUB_M, `MITE_OP_SUB_X,
         `MITE_OP_ADC_M, `MITE_OP_SBC_M, `MITE_OP_AND_M,
         `MITE_OP_OR_M, `MITE_OP_XOR_M, `MITE_OP_CPLA,
         `MITE_OP_INCREMENT_TO_ACC, `MITE_OP_DECREMENT_TO_ACC:
            to_acc = 1'b1; // [RULE13]
         `MITE_OP_MOV_M_A, `MITE_OP_CPL, `MITE_OP_INC,
         `MITE_OP_DEC, `MITE_OP_SETB, `MITE_OP_CLRB:
            to_mem = 1'b1; // [RULE11]
         `MITE_OP_RR, `MITE_OP_RL, `MITE_OP_RRC, `MITE_OP_RLC:
         begin
            // Bit field bit 0 picks accumulator as target
            to_acc = bsel[0];
            to_mem = ~bsel[0];
         end
         default:
         begin
            to_acc = 1'b0;
            to_mem = 1'b0;
         end
      endcase
   end

   // Skip decision for conditional instructions
   reg skip_take;
   always @*
   begin
      case (op)
         `MITE_OP_SZ: skip_take = (oper_reg == 8'h00); // [RULE6]
         `MITE_OP_SZB: skip_take = ~oper_reg[bsel]; // [RULE6]
         `MITE_OP_SNZB: skip_take = oper_reg[bsel]; // [RULE6]
         default: skip_take = 1'b0;
      endcase
   end

   // Write targeting pc_low_byte turns into a jump
   wire pcl_write;
   assign pcl_write = to_mem & (arg == `MITE_PCL_ADDR);

   wire [7:0] pc_inc;
   wire [7:0] pc_skip;
   wire [SP_W-1:0] sp_dec;
   assign pc_inc = pc_reg + 8'h01;
   assign pc_skip = pc_reg + 8'h02;
   assign sp_dec = sp_reg - {{(SP_W-1){1'b0}}, 1'b1};

   // Wake pin synchroniser
   always @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         wake_meta_reg <= 1'b0;
         wake_sync_reg <= 1'b0;
      end
      else
      begin
         wake_meta_reg <= wake_in;
         wake_sync_reg <= wake_meta_reg;
      end
   end

   // Return stack storage
   always @(posedge core_clk_in)
   begin
      if (phase_reg == PH_EXEC && !extra_reg && !halted_out &&
          op == `MITE_OP_CALL)
         stack_mem[sp_reg] <= pc_inc; // [RULE12]
   end

   // Four-phase sequencer and execution
   always @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         phase_reg <= PH_FETCH;
         pc_reg <= `MITE_PC_RST;
         instr_reg <= 16'h0000;
         oper_reg <= 8'h00;
         extra_reg <= 1'b0;
         tabrd_reg <= 1'b0;
         sp_reg <= {SP_W{1'b0}};
         prog_addr_out <= `MITE_PC_RST;
         dm_addr_out <= 8'h00;
         dm_wdata_out <= 8'h00;
         dm_we_out <= 1'b0;
         acc_out <= `MITE_ACC_RST;
         carry_out <= 1'b0;
         zero_out <= 1'b0;
         halted_out <= 1'b0;
         retire_out <= 1'b0;
      end
      else if (halted_out)
      begin
         // Power-down: sequencer frozen until wake
         dm_we_out <= 1'b0;
         retire_out <= 1'b0;
         if (wake_sync_reg)
            halted_out <= 1'b0; // [RULE14]
      end
      else
      begin
         dm_we_out <= 1'b0;
         retire_out <= 1'b0;
         case (phase_reg)
            PH_FETCH:
               phase_reg <= PH_DECODE; // [RULE1]
            PH_DECODE:
            begin
               phase_reg <= PH_READ; // [RULE1]
               if (extra_reg && tabrd_reg)
                  dm_wdata_out <= prog_data_in[7:0]; // Table low byte
               else if (!extra_reg)
               begin
                  instr_reg <= prog_data_in;
                  dm_addr_out <= prog_data_in[`MITE_ARG_MSB:`MITE_ARG_LSB];
               end
            end
            PH_READ:
            begin
               phase_reg <= PH_EXEC; // [RULE1]
               // pc_low_byte reads back the program counter
               if (dm_addr_out == `MITE_PCL_ADDR)
                  oper_reg <= pc_reg;
               else
                  oper_reg <= dm_rdata_in;
            end
            PH_EXEC:
            begin
               phase_reg <= PH_FETCH; // [RULE1]
               if (extra_reg)
               begin
                  // Added cycle: no new instruction executes
                  extra_reg <= 1'b0;
                  tabrd_reg <= 1'b0;
                  dm_we_out <= tabrd_reg; // [RULE2]
                  prog_addr_out <= pc_reg;
                  retire_out <= 1'b1;
               end
               else
               begin
                  // Accumulator and flag update
                  if (to_acc)
                     acc_out <= alu_res; // [RULE13]
                  if (alu_c_upd)
                     carry_out <= alu_c; // [RULE7]
                  if (alu_z_upd)
                     zero_out <= (alu_res == 8'h00); // [RULE9]
                  // Memory write, except into pc_low_byte
                  if (to_mem && !pcl_write)
                  begin
                     dm_wdata_out <= alu_res; // [RULE11]
                     dm_we_out <= 1'b1;
                  end
                  // Program flow
                  if (pcl_write)
                  begin
                     pc_reg <= alu_res; // [RULE4]
                     prog_addr_out <= alu_res;
                     extra_reg <= 1'b1;
                  end
                  else if (op == `MITE_OP_JMP)
                  begin
                     pc_reg <= arg; // [RULE12]
                     prog_addr_out <= arg;
                     extra_reg <= 1'b1; // [RULE3]
                  end
                  else if (op == `MITE_OP_CALL)
                  begin
                     sp_reg <= sp_reg + {{(SP_W-1){1'b0}}, 1'b1};
                     pc_reg <= arg;
                     prog_addr_out <= arg;
                     extra_reg <= 1'b1; // [RULE3]
                  end
                  else if (op == `MITE_OP_RET ||
                           (op == `MITE_OP_MISC &&
                            bsel == `MITE_SUB_INTERRUPT_RETURN))
                  begin
                     sp_reg <= sp_dec;
                     pc_reg <= stack_mem[sp_dec]; // [RULE12]
                     prog_addr_out <= stack_mem[sp_dec];
                     extra_reg <= 1'b1; // [RULE3]
                  end
                  else if (op == `MITE_OP_MISC &&
                           bsel == `MITE_SUB_TABRD)
                  begin
                     // Added cycle fetches table word at acc
                     pc_reg <= pc_inc;
                     prog_addr_out <= acc_out;
                     extra_reg <= 1'b1; // [RULE2]
                     tabrd_reg <= 1'b1;
                  end
                  else if (skip_take)
                  begin
                     pc_reg <= pc_skip; // [RULE6]
                     prog_addr_out <= pc_skip;
                     extra_reg <= 1'b1; // [RULE5]
                  end
                  else
                  begin
                     pc_reg <= pc_inc; // [RULE15]
                     prog_addr_out <= pc_inc;
                     retire_out <= 1'b1;
                     if (op == `MITE_OP_MISC && bsel == `MITE_SUB_HALT)
                        halted_out <= 1'b1; // [RULE14]
                  end
               end
            end
            default:
               phase_reg <= PH_FETCH;
         endcase
      end
   end

endmodule // mite_core
`default_nettype wire

// *** design/mite_core_map.vh ***
`ifndef MITE_CORE_MAP_VH
`define MITE_CORE_MAP_VH

// System clocks per instruction cycle
`define MITE_CLKS_PER_ICYCLE 4
// Instruction word fields
`define MITE_OP_MSB 15
`define MITE_OP_LSB 11
`define MITE_BIT_MSB 10
`define MITE_BIT_LSB 8
`define MITE_ARG_MSB 7
`define MITE_ARG_LSB 0
// Data memory address that maps onto pc_low_byte
`define MITE_PCL_ADDR 8'h02
// Reset values
`define MITE_PC_RST 8'h00
`define MITE_ACC_RST 8'h00
// Opcodes
`define MITE_OP_NOP 5'h00
`define MITE_OP_MOV_A_M 5'h01
`define MITE_OP_MOV_M_A 5'h02
`define MITE_OP_MOV_A_X 5'h03
`define MITE_OP_ADD_M 5'h04
`define MITE_OP_ADD_X 5'h05
`define MITE_OP_SUB_M 5'h06
`define MITE_OP_SUB_X 5'h07
`define MITE_OP_ADC_M 5'h08
`define MITE_OP_SBC_M 5'h09
`define MITE_OP_AND_M 5'h0A
`define MITE_OP_OR_M 5'h0B
`define MITE_OP_XOR_M 5'h0C
`define MITE_OP_CPL 5'h0D
`define MITE_OP_CPLA 5'h0E
`define MITE_OP_INC 5'h0F
`define MITE_OP_INCREMENT_TO_ACC 5'h10
`define MITE_OP_DEC 5'h11
`define MITE_OP_DECREMENT_TO_ACC 5'h12
`define MITE_OP_RR 5'h13
`define MITE_OP_RL 5'h14
`define MITE_OP_RRC 5'h15
`define MITE_OP_RLC 5'h16
`define MITE_OP_SETB 5'h17
`define MITE_OP_CLRB 5'h18
`define MITE_OP_SZ 5'h19
`define MITE_OP_SZB 5'h1A
`define MITE_OP_SNZB 5'h1B
`define MITE_OP_JMP 5'h1C
`define MITE_OP_CALL 5'h1D
`define MITE_OP_RET 5'h1E
`define MITE_OP_MISC 5'h1F
// Sub-codes of the misc opcode, carried in the bit field
`define MITE_SUB_INTERRUPT_RETURN 3'h0
`define MITE_SUB_HALT 3'h1
`define MITE_SUB_TABRD 3'h2

`endif

// *** design/mite_alu.v ***
`timescale 1ns/1ps
`default_nettype none
`include "mite_core_map.vh"

module mite_alu
(
   // Operation select
   input wire [4:0] op_in,
   input wire [2:0] bit_in,
   // Operands
   input wire [7:0] acc_in,
   input wire [7:0] mem_in,
   input wire [7:0] imm_in,
   input wire carry_in,
   // Results
   output reg [7:0] res_out,
   output reg carry_new_out,
   output reg carry_upd_out,
   output reg zero_upd_out
);

   // Wide sum keeps the ninth bit for carry and borrow
   reg [8:0] wide;
   // Single-bit mask for set and clear
   wire [7:0] mask;
   assign mask = 8'h01 << bit_in;

   // Operation decode
   always @*
   begin
      wide = 9'h000;
      res_out = mem_in;
      carry_new_out = carry_in;
      carry_upd_out = 1'b0;
      zero_upd_out = 1'b0;
      case (op_in)
         `MITE_OP_MOV_A_M: res_out = mem_in; // [RULE13]
         `MITE_OP_MOV_M_A: res_out = acc_in; // [RULE13]
         `MITE_OP_MOV_A_X: res_out = imm_in; // [RULE13]
         `MITE_OP_ADD_M, `MITE_OP_ADD_X, `MITE_OP_ADC_M:
         begin
            // Carry out when sum passes 255
            wide = {1'b0, acc_in} +
               {1'b0, (op_in == `MITE_OP_ADD_X) ? imm_in : mem_in} +
               {8'h00, (op_in == `MITE_OP_ADC_M) & carry_in};
            res_out = wide[7:0];
            carry_new_out = wide[8]; // [RULE7]
            carry_upd_out = 1'b1;
            zero_upd_out = 1'b1;
         end
         `MITE_OP_SUB_M, `MITE_OP_SUB_X, `MITE_OP_SBC_M:
         begin
            // Borrow when difference drops below 0
            wide = {1'b0, acc_in} -
               {1'b0, (op_in == `MITE_OP_SUB_X) ? imm_in : mem_in} -
               {8'h00, (op_in == `MITE_OP_SBC_M) & carry_in};
            res_out = wide[7:0];
            carry_new_out = wide[8]; // [RULE7]
            carry_upd_out = 1'b1;
            zero_upd_out = 1'b1;
         end
         `MITE_OP_AND_M:
         begin
            res_out = acc_in & mem_in;
            zero_upd_out = 1'b1; // [RULE9]
         end
         `MITE_OP_OR_M:
         begin
            res_out = acc_in | mem_in;
            zero_upd_out = 1'b1; // [RULE9]
         end
         `MITE_OP_XOR_M:
         begin
            res_out = acc_in ^ mem_in;
            zero_upd_out = 1'b1; // [RULE9]
         end
         `MITE_OP_CPL, `MITE_OP_CPLA:
         begin
            res_out = ~mem_in;
            zero_upd_out = 1'b1; // [RULE9]
         end
         `MITE_OP_INC, `MITE_OP_INCREMENT_TO_ACC:
         begin
            res_out = mem_in + 8'h01; // [RULE8]
            zero_upd_out = 1'b1;
         end
         `MITE_OP_DEC, `MITE_OP_DECREMENT_TO_ACC:
         begin
            res_out = mem_in - 8'h01; // [RULE8]
            zero_upd_out = 1'b1;
         end
         `MITE_OP_RR: res_out = {mem_in[0], mem_in[7:1]}; // [RULE10]
         `MITE_OP_RL: res_out = {mem_in[6:0], mem_in[7]}; // [RULE10]
         `MITE_OP_RRC:
         begin
            // Bit 0 leaves through carry
            res_out = {carry_in, mem_in[7:1]}; // [RULE10]
            carry_new_out = mem_in[0];
            carry_upd_out = 1'b1;
         end
         `MITE_OP_RLC:
         begin
            // Bit 7 leaves through carry
            res_out = {mem_in[6:0], carry_in}; // [RULE10]
            carry_new_out = mem_in[7];
            carry_upd_out = 1'b1;
         end
         `MITE_OP_SETB: res_out = mem_in | mask; // [RULE11]
         `MITE_OP_CLRB: res_out = mem_in & ~mask; // [RULE11]
         default: res_out = mem_in;
      endcase
   end

endmodule // mite_alu
`default_nettype wire

// *** dv/mite_core_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mite_core_map.vh"
module mite_core_checker
#(
   parameter STACK_DEPTH = 4,
   parameter SP_W = 2
)
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Memory side
   input wire logic [7:0] prog_addr_out,
   input wire logic [7:0] dm_addr_out,
   input wire logic dm_we_out,
   // Wake and status
   input wire logic wake_in,
   input wire logic [7:0] acc_out,
   input wire logic carry_out,
   input wire logic zero_out,
   input wire logic halted_out,
   input wire logic retire_out
);
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);
   // Three quiet cycles after a retirement
   sequence quiet_three;
      !retire_out [*3];
   endsequence
   // Core held in power-down for two cycles
   sequence halted_two;
      halted_out [*2];
   endsequence
   // Any accumulator, carry or zero flag update
   sequence state_moves;
      $changed(acc_out) || $changed(carry_out) || $changed(zero_out);
   endsequence
   retire_gap_a: assert property (retire_out |=> quiet_three)
      else $error("retirements closer than four clocks");
   retire_bound_a:
      assert property (retire_out ##1 !retire_out [*8] |-> halted_out)
      else $error("instruction longer than two cycles");
   pcl_block_a:
      assert property (dm_we_out |-> dm_addr_out != `MITE_PCL_ADDR)
      else $error("program counter write reached data memory");
   we_pulse_a: assert property (dm_we_out |=> !dm_we_out)
      else $error("write strobe longer than one clock");
   halt_freeze_a:
      assert property (halted_two |-> $stable(prog_addr_out) && !retire_out)
      else $error("core advanced while powered down");
   wake_exit_a:
      assert property ($rose(wake_in) && halted_out |-> ##[1:8] !halted_out)
      else $error("wake did not leave power-down");
   acc_cadence_a:
      assert property (state_moves |=> ($stable(acc_out)
         && $stable(carry_out) && $stable(zero_out)) [*3])
      else $error("state updated twice in one instruction cycle");
   pc_retire_a:
      assert property ($changed(prog_addr_out) |-> ##[0:5] retire_out)
      else $error("program counter moved without retirement");
endmodule // mite_core_checker
bind mite_core mite_core_checker #(.STACK_DEPTH(STACK_DEPTH), .SP_W(SP_W)) u_chk
(
   .core_clk_in(core_clk_in), .rst_in(rst_in), .wake_in(wake_in),
   .prog_addr_out(prog_addr_out), .dm_addr_out(dm_addr_out),
   .dm_we_out(dm_we_out), .acc_out(acc_out), .carry_out(carry_out),
   .zero_out(zero_out), .halted_out(halted_out), .retire_out(retire_out)
);
`default_nettype wire

// *** dv/mite_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mite_mem_model
(
   // Clock
   input wire logic core_clk_in,
   // Program side
   input wire logic [7:0] prog_addr_in,
   output logic [15:0] prog_data_out,
   // Data side
   input wire logic [7:0] dm_addr_in,
   output logic [7:0] dm_rdata_out,
   input wire logic [7:0] dm_wdata_in,
   input wire logic dm_we_in
);
   // Storage, filled by the bench before reset release
   logic [15:0] prog [0:255];
   logic [7:0] dm [0:255];
   // Reads settle well inside one clock
   assign prog_data_out = prog[prog_addr_in];
   assign dm_rdata_out = dm[dm_addr_in];
   // Write taken at the edge that ends the strobe cycle
   always @(posedge core_clk_in)
   begin
      if (dm_we_in)
         dm[dm_addr_in] <= dm_wdata_in;
   end
endmodule // mite_mem_model
`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mite_core_map.vh"
module testbench;
   // Expected state after one retirement
   typedef struct packed {
      logic [7:0] acc;
      logic c;
      logic z;
      logic [7:0] pc;
      logic [3:0] gap;
   } mite_note_t;
   localparam logic [15:0] poison_word = {`MITE_OP_MOV_A_X, 3'h0, 8'hEE};
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic wake_in = 1'b0;
   wire logic [7:0] p_addr, d_addr, d_rd, d_wd, acc;
   wire logic [15:0] p_data;
   wire logic d_we, carry, zero, halted, retire;
   // Shadow machine
   logic [7:0] s_acc, s_pc, s_dm [0:255], stk [0:3];
   logic s_c, s_z, nogap;
   int sp = 0;
   mite_note_t notes [$];
   mite_note_t got, exp_n;
   int n_fail = 0;
   int n_checks = 0;
   int cycles = 0;
   int gap_cnt = 0;
   int rest = 0; // Notes left behind the first halt
   int i;
   integer seed = 32'h8E01;
   always #5 core_clk_in = ~core_clk_in;
   mite_core dut
   (
      .core_clk_in(core_clk_in), .rst_in(rst_in), .prog_addr_out(p_addr),
      .prog_data_in(p_data), .dm_addr_out(d_addr), .dm_rdata_in(d_rd),
      .dm_wdata_out(d_wd), .dm_we_out(d_we), .wake_in(wake_in),
      .acc_out(acc), .carry_out(carry), .zero_out(zero),
      .halted_out(halted), .retire_out(retire)
   );
   mite_mem_model mem
   (
      .core_clk_in(core_clk_in), .prog_addr_in(p_addr),
      .prog_data_out(p_data), .dm_addr_in(d_addr), .dm_rdata_out(d_rd),
      .dm_wdata_in(d_wd), .dm_we_in(d_we)
   );
   function automatic logic [7:0] rnd();
      rnd = $random(seed);
   endfunction
   task automatic check(input logic [23:0] g, input logic [23:0] e);
      n_checks = n_checks + 1;
      if (g !== e)
      begin
         n_fail = n_fail + 1;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic conclude();
      if (n_fail == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Place one word and step the shadow machine over it
   task automatic emit(input logic [4:0] op, input logic [2:0] b,
      input logic [7:0] a);
      logic [7:0] v, npc;
      logic [12:0] t;
      logic [3:0] g;
      logic skip;
      mem.prog[s_pc] = {op, b, a};
      if (op == `MITE_OP_MISC && b == `MITE_SUB_INTERRUPT_RETURN)
         op = `MITE_OP_RET;
      {v, npc, g, skip} = {s_dm[a], s_pc + 8'h01, 4'h4, 1'h0};
      // Fields: to acc, to memory, zero, carry, 9-bit result
      case (op)
         `MITE_OP_MOV_A_M: t = {4'h8, 1'h0, v};
         `MITE_OP_MOV_M_A: t = {4'h4, 1'h0, s_acc};
         `MITE_OP_MOV_A_X: t = {4'h8, 1'h0, a};
         `MITE_OP_ADD_M: t = {4'hB, {1'h0, s_acc} + {1'h0, v}};
         `MITE_OP_ADD_X: t = {4'hB, {1'h0, s_acc} + {1'h0, a}};
         `MITE_OP_SUB_M: t = {4'hB, {1'h0, s_acc} - {1'h0, v}};
         `MITE_OP_SUB_X: t = {4'hB, {1'h0, s_acc} - {1'h0, a}};
         `MITE_OP_ADC_M: t = {4'hB, {1'h0, s_acc} + {1'h0, v} + {8'h00, s_c}};
         `MITE_OP_SBC_M: t = {4'hB, {1'h0, s_acc} - {1'h0, v} - {8'h00, s_c}};
         `MITE_OP_AND_M: t = {4'hA, 1'h0, s_acc & v};
         `MITE_OP_OR_M: t = {4'hA, 1'h0, s_acc | v};
         `MITE_OP_XOR_M: t = {4'hA, 1'h0, s_acc ^ v};
         `MITE_OP_CPL: t = {4'h6, 1'h0, ~v};
         `MITE_OP_CPLA: t = {4'hA, 1'h0, ~v};
         `MITE_OP_INC: t = {4'h6, 1'h0, v + 8'h01};
         `MITE_OP_INCREMENT_TO_ACC: t = {4'hA, 1'h0, v + 8'h01};
         `MITE_OP_DEC: t = {4'h6, 1'h0, v - 8'h01};
         `MITE_OP_DECREMENT_TO_ACC: t = {4'hA, 1'h0, v - 8'h01};
         `MITE_OP_RR: t = {b[0], ~b[0], 3'h0, v[0], v[7:1]};
         `MITE_OP_RL: t = {b[0], ~b[0], 3'h0, v[6:0], v[7]};
         `MITE_OP_RRC: t = {b[0], ~b[0], 2'h1, v[0], s_c, v[7:1]};
         `MITE_OP_RLC: t = {b[0], ~b[0], 2'h1, v[7], v[6:0], s_c};
         `MITE_OP_SETB: t = {4'h4, 1'h0, v | (8'h01 << b)};
         `MITE_OP_CLRB: t = {4'h4, 1'h0, v & ~(8'h01 << b)};
         default: t = 13'h0000;
      endcase
      if (t[12])
         s_acc = t[7:0];
      if (t[10])
         s_z = (t[7:0] == 8'h00);
      if (t[9])
         s_c = t[8];
      if (t[11] && a == `MITE_PCL_ADDR)
         {npc, g} = {t[7:0], 4'h8};
      else if (t[11])
         s_dm[a] = t[7:0];
      case (op)
         `MITE_OP_SZ: skip = (v == 8'h00);
         `MITE_OP_SZB: skip = !v[b];
         `MITE_OP_SNZB: skip = v[b];
         `MITE_OP_JMP: {npc, g} = {a, 4'h8};
         `MITE_OP_CALL:
         begin
            stk[sp] = npc;
            sp = sp + 1;
            {npc, g} = {a, 4'h8};
         end
         `MITE_OP_RET:
         begin
            sp = sp - 1;
            {npc, g} = {stk[sp], 4'h8};
         end
         `MITE_OP_MISC:
            if (b == `MITE_SUB_TABRD)
               {s_dm[a], g} = {mem.prog[s_acc][7:0], 4'h8};
         default: skip = 1'h0;
      endcase
      if (skip)
         {npc, g} = {npc + 8'h01, 4'h8};
      notes.push_back({s_acc, s_c, s_z, npc, nogap ? 4'h0 : g});
      nogap = (op == `MITE_OP_MISC && b == `MITE_SUB_HALT);
      s_pc = npc;
   endtask
   // Every data and bit operation once, random operands
   task automatic alu_pass();
      logic [4:0] op;
      logic [7:0] a, b;
      for (op = 5'h01; op <= 5'h18; op++)
      begin
         {a, b} = {rnd(), rnd()};
         if (op != `MITE_OP_MOV_A_X && op != `MITE_OP_ADD_X &&
            op != `MITE_OP_SUB_X)
            a = {4'h1, a[3:0]};
         emit(op, b[2:0], a);
      end
   endtask
   initial
   begin
      for (i = 0; i < 256; i++)
      begin
         mem.prog[i] = poison_word;
         mem.dm[i] = rnd();
         s_dm[i] = mem.dm[i];
      end
      mem.prog[8'hF0] = {rnd(), rnd()};
      {s_acc, s_c, s_z, s_pc, nogap} = {8'h00, 1'h0, 1'h0, 8'h00, 1'h1};
      alu_pass();
      // Byte boundary, then skips taken and not taken
      emit(`MITE_OP_MOV_A_X, 3'h0, 8'hFF);
      emit(`MITE_OP_ADD_X, 3'h0, 8'h01);
      emit(`MITE_OP_SUB_X, 3'h0, 8'h01);
      emit(`MITE_OP_MOV_A_X, 3'h0, 8'h00);
      emit(`MITE_OP_MOV_M_A, 3'h0, 8'h20);
      emit(`MITE_OP_SZ, 3'h0, 8'h20);
      emit(`MITE_OP_SZ, 3'h0, 8'h11);
      for (i = 0; i < 8; i++)
      begin
         emit(`MITE_OP_SZB, i[2:0], 8'h12);
         emit(`MITE_OP_SNZB, i[2:0], 8'h12);
      end
      // Jump, two calls, table read, program counter write, halt
      emit(`MITE_OP_JMP, 3'h0, 8'h60);
      emit(`MITE_OP_CALL, 3'h0, 8'hA0);
      emit(`MITE_OP_INCREMENT_TO_ACC, 3'h0, 8'h13);
      emit(`MITE_OP_RET, 3'h0, 8'h00);
      emit(`MITE_OP_CALL, 3'h0, 8'hB0);
      emit(`MITE_OP_MISC, `MITE_SUB_INTERRUPT_RETURN, 8'h00);
      emit(`MITE_OP_MOV_A_X, 3'h0, 8'hF0);
      emit(`MITE_OP_MISC, `MITE_SUB_TABRD, 8'h22);
      emit(`MITE_OP_MOV_A_X, 3'h0, 8'hC0);
      emit(`MITE_OP_MOV_M_A, 3'h0, `MITE_PCL_ADDR);
      emit(`MITE_OP_MISC, `MITE_SUB_HALT, 8'h00);
      rest = notes.size();
      alu_pass();
      emit(`MITE_OP_MISC, `MITE_SUB_HALT, 8'h00);
      rest = notes.size() - rest;
      repeat (10) @(negedge core_clk_in);
      rst_in = 1'b0;
      for (i = 0; i < 2; i++)
      begin
         while (halted !== 1'b1)
            @(negedge core_clk_in);
         repeat (10) @(negedge core_clk_in);
         check(24'(notes.size()), (i == 0) ? 24'(rest) : 24'h0);
         if (i == 0)
         begin
            wake_in = 1'b1;
            repeat (8) @(negedge core_clk_in);
            wake_in = 1'b0;
         end
      end
      for (i = 16; i < 48; i++)
         check({16'h0, mem.dm[i]}, {16'h0, s_dm[i]});
      conclude();
   end
   // Match each retirement against the oldest note
   always @(posedge core_clk_in)
   begin
      gap_cnt = gap_cnt + 1;
      if (rst_in === 1'b0 && retire === 1'b1)
      begin
         exp_n = (notes.size() > 0) ? notes.pop_front() : '1;
         got = {acc, carry, zero, p_addr, gap_cnt[3:0]};
         if (exp_n.gap == 4'h0)
            got.gap = 4'h0;
         check({2'h0, got}, {2'h0, exp_n});
         gap_cnt = 0;
      end
   end
   // Cut a hung run short
   always @(posedge core_clk_in)
   begin
      cycles = cycles + 1;
      if (cycles == 5000)
      begin
         n_fail = n_fail + 1;
         conclude();
      end
   end
endmodule // testbench
`default_nettype wire
